/* File: pidc_pkg.sv */
// package: constants, types and register map of the pid process controller
package pidc_pkg;
	// ==================================
	// register offsets (word index == byte address / 4)
	localparam logic [7:0] ADDR_ACTION    = 8'h00;
	localparam logic [7:0] ADDR_PBAND     = 8'h04;
	localparam logic [7:0] ADDR_ITIME     = 8'h08;
	localparam logic [7:0] ADDR_UPPER     = 8'h0C;
	localparam logic [7:0] ADDR_LOWER     = 8'h10;
	localparam logic [7:0] ADDR_SETPOINT  = 8'h14;
	localparam logic [7:0] ADDR_DTIME     = 8'h18;
	localparam logic [7:0] ADDR_CONFIG    = 8'h1C;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;
	localparam logic [7:0] ADDR_OUTPUT    = 8'h24;
	// ==================================
	// encodings and reset values (settings in tenths of a unit, derivative time in hundredths)
	localparam logic [15:0] SEL_DEV_REVERSE = 16'h000A; // 10
	localparam logic [15:0] SEL_DEV_FORWARD = 16'h000B; // 11
	localparam logic [15:0] SEL_PV_REVERSE  = 16'h001E; // 30
	localparam logic [15:0] SEL_PV_FORWARD  = 16'h001F; // 31
	localparam logic [15:0] DISABLED_CODE = 16'h270F; // 9999
	localparam logic [15:0] RST_ACTION    = SEL_DEV_REVERSE;
	localparam logic [15:0] RST_PBAND     = 16'h03E8; // 100.0 % in tenths
	localparam logic [15:0] RST_ITIME     = 16'h000A; // 1.0 s in tenths
	localparam logic [15:0] RST_UPPER     = DISABLED_CODE;
	localparam logic [15:0] RST_LOWER     = DISABLED_CODE;
	localparam logic [15:0] RST_SETPOINT  = 16'h0000;
	localparam logic [15:0] RST_DTIME     = DISABLED_CODE; // hundredths of s
	localparam logic [15:0] PBAND_MIN     = 16'h0001;
	localparam logic [15:0] PBAND_MAX     = 16'h2710; // 1000.0 %
	localparam logic [15:0] ITIME_MIN     = 16'h0001;
	localparam logic [15:0] ITIME_MAX     = 16'h8CA0; // 3600.0 s
	localparam logic [15:0] DTIME_MIN     = 16'h0001;
	localparam logic [15:0] DTIME_MAX     = 16'h03E8; // 10.00 s
	localparam logic [15:0] PCT_MAX       = 16'h03E8; // 100.0 %
	// config bits
	localparam int CFG_SP_ANALOG = 0; // 1: set point from analog terminal
	localparam int CFG_LEGACY    = 1; // 1: clamp negative process values
	localparam int CFG_DIR_FORWARD = 2; // commanded direction forward
	localparam int CFG_RUN       = 3; // drive running
	// ==================================
	// sample timing
	localparam int SAMPLE_US    = 1000;
	localparam int CLK_MHZ      = 10;
	localparam int SAMPLE_CYC   = SAMPLE_US * CLK_MHZ;
	localparam int SAMPLES_PER_S = 1000000 / SAMPLE_US;
	// full scale: 100.0 % == 1000 counts (tenths of a percent)
	localparam logic signed [15:0] FS_POS = 16'sh03E8;
	localparam logic signed [15:0] FS_NEG = -16'sh03E8;
	// ==================================
	// carriers
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} pidc_bus_req_t;
	typedef struct packed {
		logic [15:0] action;
		logic [15:0] pband;
		logic [15:0] itime;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] setpoint;
		logic [15:0] dtime;
		logic [3:0]  config_bits;
	} pidc_cfg_t;
endpackage : pidc_pkg

/* File: pidc_sync.sv */
// module: three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pidc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pidc_sync_st_t;
	pidc_sync_st_t st, next_st;
	// ==================================
	// stages; the output follows once stages two and three agree
	always_comb begin
		next_st    = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign dout = st.q;
endmodule : pidc_sync
`default_nettype wire

/* File: pidc_top.sv */
// module: pid process controller top with settings registers and control loop
`timescale 1ns/100ps
`default_nettype none
module pidc_top
	import pidc_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire pidc_pkg::pidc_bus_req_t bus_req,
	output var  logic [15:0]         bus_rdata,
	input  wire logic                pid_select_input,
	input  wire logic signed [15:0]  aux_input,
	input  wire logic signed [15:0]  setpoint_input,
	input  wire logic signed [15:0]  speed_ref_input,
	output var  logic signed [15:0]  speed_ref_out,
	output var  logic                direction_indicator_output,
	output var  logic                upper_limit_flag,
	output var  logic                lower_limit_flag
);
	import pidc_pkg::*;

	typedef struct packed {
		pidc_cfg_t          cfg;
		logic [15:0]        rdata;
		logic [31:0]        tick;
		logic signed [31:0] integ;
		logic signed [15:0] prev_dev;
		logic signed [15:0] out;
		logic               dir;
		logic               up;
		logic               dn;
	} pidc_st_t;

	pidc_st_t st, next_st;
	logic sel_sync;

	// ==================================
	// select input synchroniser
	pidc_sync #(.W(1)) u_sel_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (pid_select_input),
		.dout   (sel_sync)
	);

	// ==================================
	// saturation helper
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		logic signed [15:0] r;
		r = v[15:0];
		if (v > 48'(FS_POS)) begin
			r = FS_POS;
		end else if (v < 48'(FS_NEG)) begin
			r = FS_NEG;
		end
		return r;
	endfunction : sat16

	// ==================================
	// combinational working values
	logic               mode_ok;
	logic               pv_mode;
	logic               forward_act;
	logic signed [15:0] pv;
	logic signed [15:0] sp;
	logic signed [15:0] dev;
	logic signed [15:0] err;
	logic signed [47:0] p_term;
	logic signed [47:0] i_inc;
	logic signed [47:0] d_term;
	logic signed [47:0] sum;
	logic signed [31:0] next_integ;
	logic               sample;

	always_comb begin
		mode_ok = (st.cfg.action == SEL_DEV_REVERSE) || (st.cfg.action == SEL_DEV_FORWARD)
			|| (st.cfg.action == SEL_PV_REVERSE) || (st.cfg.action == SEL_PV_FORWARD);
		pv_mode = (st.cfg.action == SEL_PV_REVERSE) || (st.cfg.action == SEL_PV_FORWARD);
		forward_act = (st.cfg.action == SEL_DEV_FORWARD) || (st.cfg.action == SEL_PV_FORWARD);
		// auxiliary input already in tenths of percent, full scale clamp
		pv = sat16(48'(aux_input));
		if (st.cfg.config_bits[CFG_LEGACY] && pv < 16'sh0000) begin
			pv = 16'sh0000;
		end
		// set point terminal is unipolar
		sp = sat16(48'(setpoint_input));
		if (sp < 16'sh0000) begin
			sp = 16'sh0000;
		end
		if (!st.cfg.config_bits[CFG_SP_ANALOG]) begin
			sp = $signed(st.cfg.setpoint);
		end
		if (pv_mode) begin
			dev = sat16(48'(sp) - 48'(pv));
		end else begin
			dev = pv;
		end
		// forward action flips the sign of the control error
		err = forward_act ? -dev : dev;
		// proportional: err * 1000 / band
		if (st.cfg.pband == DISABLED_CODE) begin
			p_term = '0;
		end else begin
			p_term = (48'(err) * 48'sd1000) / 48'($signed({1'b0, st.cfg.pband}));
		end
		// integral increment per sample: p / (Ti * samples per s)
		if (st.cfg.itime == DISABLED_CODE) begin
			i_inc = '0;
		end else begin
			i_inc = (p_term * 48'sd10 * 48'sd256)
				/ (48'($signed({1'b0, st.cfg.itime})) * 48'(SAMPLES_PER_S));
		end
		// derivative: Td * error delta per second, without the band gain
		if (st.cfg.dtime == DISABLED_CODE) begin
			d_term = '0;
		end else begin
			d_term = (48'(err - (forward_act ? -st.prev_dev : st.prev_dev)) * 48'($signed({1'b0, st.cfg.dtime}))
				* 48'(SAMPLES_PER_S)) / 48'sd100;
		end
		next_integ = st.integ + 32'(i_inc);
		// anti-windup: bound the integral to full scale
		if (next_integ > 32'(FS_POS) * 256) begin
			next_integ = 32'(FS_POS) * 256;
		end else if (next_integ < 32'(FS_NEG) * 256) begin
			next_integ = 32'(FS_NEG) * 256;
		end
		sum = p_term + 48'(next_integ >>> 8) + d_term;
		sample = (st.tick >= 32'(SAMPLE_CYCLES - 1));
	end

	// ==================================
	// next-state logic
	always_comb begin
		next_st       = st;
		next_st.rdata = '0;
		// settings writes with range checks
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				ADDR_ACTION: begin
					if (bus_req.wdata == SEL_DEV_REVERSE || bus_req.wdata == SEL_DEV_FORWARD
						|| bus_req.wdata == SEL_PV_REVERSE || bus_req.wdata == SEL_PV_FORWARD) begin
						next_st.cfg.action = bus_req.wdata;
					end
				end
				ADDR_PBAND: begin
					if ((bus_req.wdata >= PBAND_MIN && bus_req.wdata <= PBAND_MAX)
						|| bus_req.wdata == DISABLED_CODE) begin
						next_st.cfg.pband = bus_req.wdata;
					end
				end
				ADDR_ITIME: begin
					if ((bus_req.wdata >= ITIME_MIN && bus_req.wdata <= ITIME_MAX)
						|| bus_req.wdata == DISABLED_CODE) begin
						next_st.cfg.itime = bus_req.wdata;
					end
				end
				ADDR_UPPER: begin
					if (bus_req.wdata <= PCT_MAX || bus_req.wdata == DISABLED_CODE) begin
						next_st.cfg.upper = bus_req.wdata;
					end
				end
				ADDR_LOWER: begin
					if (bus_req.wdata <= PCT_MAX || bus_req.wdata == DISABLED_CODE) begin
						next_st.cfg.lower = bus_req.wdata;
					end
				end
				ADDR_SETPOINT: begin
					if (bus_req.wdata <= PCT_MAX) begin
						next_st.cfg.setpoint = bus_req.wdata;
					end
				end
				ADDR_DTIME: begin
					if ((bus_req.wdata >= DTIME_MIN && bus_req.wdata <= DTIME_MAX)
						|| bus_req.wdata == DISABLED_CODE) begin
						next_st.cfg.dtime = bus_req.wdata;
					end
				end
				ADDR_CONFIG: begin
					next_st.cfg.config_bits = bus_req.wdata[3:0];
				end
				default: begin
				end
			endcase
		end
		// register reads, data valid the next cycle
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				ADDR_ACTION:   next_st.rdata = st.cfg.action;
				ADDR_PBAND:    next_st.rdata = st.cfg.pband;
				ADDR_ITIME:    next_st.rdata = st.cfg.itime;
				ADDR_UPPER:    next_st.rdata = st.cfg.upper;
				ADDR_LOWER:    next_st.rdata = st.cfg.lower;
				ADDR_SETPOINT: next_st.rdata = st.cfg.setpoint;
				ADDR_DTIME:    next_st.rdata = st.cfg.dtime;
				ADDR_CONFIG:   next_st.rdata = {12'h000, st.cfg.config_bits};
				ADDR_STATUS:   next_st.rdata = {12'h000, sel_sync, st.dir, st.dn, st.up};
				ADDR_OUTPUT:   next_st.rdata = st.out;
				default:       next_st.rdata = '0;
			endcase
		end
		// sample tick
		next_st.tick = sample ? '0 : st.tick + 32'd1;
		// pid only while selected; otherwise pass normal speed through
		if (sel_sync && mode_ok) begin
			if (sample) begin
				next_st.integ    = next_integ;
				next_st.prev_dev = dev;
				next_st.out      = sat16(sum);
			end
		end else begin
			next_st.integ    = '0;
			next_st.prev_dev = '0;
			next_st.out      = speed_ref_input;
		end
		// limit flags in process-value mode
		next_st.up = sel_sync && pv_mode && st.cfg.upper != DISABLED_CODE
			&& pv > $signed(st.cfg.upper);
		next_st.dn = sel_sync && pv_mode && st.cfg.lower != DISABLED_CODE
			&& pv < $signed(st.cfg.lower);
		// direction: high only when running forward
		next_st.dir = st.cfg.config_bits[CFG_RUN] && st.cfg.config_bits[CFG_DIR_FORWARD];
	end

	// ==================================
	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st              <= '0;
			st.cfg.action   <= RST_ACTION;
			st.cfg.pband    <= RST_PBAND;
			st.cfg.itime    <= RST_ITIME;
			st.cfg.upper    <= RST_UPPER;
			st.cfg.lower    <= RST_LOWER;
			st.cfg.setpoint <= RST_SETPOINT;
			st.cfg.dtime    <= RST_DTIME;
		end else begin
			st <= next_st;
		end
	end

	// ==================================
	// outputs straight from flops
	assign bus_rdata                  = st.rdata;
	assign speed_ref_out              = st.out;
	assign direction_indicator_output = st.dir;
	assign upper_limit_flag           = st.up;
	assign lower_limit_flag           = st.dn;
endmodule : pidc_top
`default_nettype wire

/* File: pidc_monitor.sv */
// checker: port-level properties of the pid process controller
`timescale 1ns/100ps
`default_nettype none
module pidc_monitor
	import pidc_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
	input wire logic                    clk,
	input wire logic                    arst_n,
	input wire pidc_pkg::pidc_bus_req_t bus_req,
	input wire logic [15:0]             bus_rdata,
	input wire logic                    pid_select_input,
	input wire logic signed [15:0]      aux_input,
	input wire logic signed [15:0]      setpoint_input,
	input wire logic signed [15:0]      speed_ref_input,
	input wire logic signed [15:0]      speed_ref_out,
	input wire logic                    direction_indicator_output,
	input wire logic                    upper_limit_flag,
	input wire logic                    lower_limit_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] since;
	// ==========
	// cycles since the output last moved
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) since <= 8'h00;
		else if ($changed(speed_ref_out)) since <= 8'h00;
		else if (since != 8'hff) since <= since + 8'h01;
	end
	// ==========
	// properties
	AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
		else $error("read data not idle");
	AST_RD_UNMAP: assert property (bus_req.rd && bus_req.addr > ADDR_OUTPUT |=> bus_rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_OUT_READ: assert property (bus_req.rd && bus_req.addr == ADDR_OUTPUT ##1 $stable(speed_ref_out)
		|-> bus_rdata == speed_ref_out) else $error("output read wrong");
	AST_STATUS_READ: assert property (bus_req.rd && bus_req.addr == ADDR_STATUS ##1
		($stable(upper_limit_flag) && $stable(lower_limit_flag) && $stable(direction_indicator_output))
		|-> bus_rdata[2:0] == {direction_indicator_output, lower_limit_flag, upper_limit_flag})
		else $error("status read wrong");
	AST_FLAGS_OFF: assert property (!pid_select_input [*6] |-> !upper_limit_flag && !lower_limit_flag)
		else $error("limit flag while pid off");
	AST_PASS: assert property (!pid_select_input [*6] |=> speed_ref_out == $past(speed_ref_input))
		else $error("no pass-through while pid off");
	AST_SAT: assert property (pid_select_input && $past(pid_select_input, 8) && $past(pid_select_input, 16)
		|-> speed_ref_out <= FS_POS && speed_ref_out >= FS_NEG) else $error("output not saturated");
	AST_HOLD: assert property ($changed(speed_ref_out) && pid_select_input && $past(pid_select_input, 16)
		|-> since >= 8'(SAMPLE_CYCLES - 1)) else $error("output moved between samples");
	// main scenarios reached
	cover property (upper_limit_flag);
	cover property (lower_limit_flag);
	cover property (speed_ref_out == FS_POS);
endmodule : pidc_monitor
bind pidc_top pidc_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_mon (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .pid_select_input(pid_select_input), .aux_input(aux_input),
	.setpoint_input(setpoint_input), .speed_ref_input(speed_ref_input), .speed_ref_out(speed_ref_out),
	.direction_indicator_output(direction_indicator_output), .upper_limit_flag(upper_limit_flag),
	.lower_limit_flag(lower_limit_flag));
`default_nettype wire

/* File: pidc_plant.sv */
// model: process detector feeding the auxiliary terminal
`timescale 1ns/100ps
`default_nettype none
module pidc_plant (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic signed [15:0] speed_ref,
	input  wire logic               hold,
	input  wire logic signed [15:0] hold_val,
	output var  logic signed [15:0] pv
);
	// process creeps toward the drive speed unless pinned, inside the terminal span
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) pv <= 16'sh0000;
		else if (hold) pv <= hold_val;
		else if (pv < speed_ref && pv < 16'sh03e8) pv <= pv + 16'sh0001;
		else if (pv > speed_ref && pv > -16'sh03e8) pv <= pv - 16'sh0001;
	end
endmodule : pidc_plant
`default_nettype wire

/* File: pidc_top_tb.sv */
// testbench: directed and random checks of the pid process controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module pidc_top_tb;
	import pidc_pkg::*;
	localparam int SC = 8;
	logic               clk = 1'b0;
	logic               arst_n = 1'b0;
	logic               sel = 1'b0;
	logic               hold = 1'b1;
	pidc_bus_req_t      req = '0;
	logic [15:0]        rdata, d;
	logic signed [15:0] aux, sout, o1, x, sp;
	logic signed [15:0] spin = '0;
	logic signed [15:0] sref = '0;
	logic signed [15:0] pv = '0;
	logic               dir, up, dn;
	int                 bad_count = 0;
	int                 tests_run = 0;
	logic [15:0] dflt [11] = '{RST_ACTION, RST_PBAND, RST_ITIME, RST_UPPER, RST_LOWER, RST_SETPOINT, RST_DTIME,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [47:0] wtab [7] = '{{ADDR_PBAND, 8'h00, PBAND_MAX + 16'h0001, RST_PBAND},
		{ADDR_PBAND, 8'h00, PBAND_MIN, PBAND_MIN}, {ADDR_ITIME, 8'h00, ITIME_MAX, ITIME_MAX},
		{ADDR_ITIME, 8'h00, 16'h0000, ITIME_MAX}, {ADDR_DTIME, 8'h00, DTIME_MAX + 16'h0001, RST_DTIME},
		{ADDR_SETPOINT, 8'h00, PCT_MAX + 16'h0001, RST_SETPOINT}, {ADDR_ACTION, 8'h00, 16'h000c, RST_ACTION}};
	logic [15:0] acts [4] = '{SEL_DEV_REVERSE, SEL_DEV_FORWARD, SEL_PV_REVERSE, SEL_PV_FORWARD};
	logic [15:0] bands [4] = '{16'h01f4, 16'h03e8, 16'h07d0, DISABLED_CODE};
	logic [15:0] fpv [7] = '{16'h02bc, 16'h0064, 16'h0190, 16'h0258, 16'h00c8, 16'h02bc, 16'h02bc};
	logic [1:0]  fexp [7] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00};
	// ==========
	// clock, design and process model
	always #50 clk = ~clk;
	pidc_top #(.SAMPLE_CYCLES(SC)) i_dut (.clk(clk), .arst_n(arst_n), .bus_req(req), .bus_rdata(rdata),
		.pid_select_input(sel), .aux_input(aux), .setpoint_input(spin), .speed_ref_input(sref),
		.speed_ref_out(sout), .direction_indicator_output(dir), .upper_limit_flag(up), .lower_limit_flag(dn));
	pidc_plant i_plant (.clk(clk), .arst_n(arst_n), .speed_ref(sout), .hold(hold), .hold_val(pv), .pv(aux));
	// ==========
	// bus cycles, settling and the verdict
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk) req <= '0;
		@(negedge clk) v = rdata;
	endtask : rd
	task automatic settle;
		repeat (3 * SC) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// proportional-only answer for held inputs
	function automatic logic signed [15:0] pexp(input logic [15:0] act, band, input logic signed [15:0] s, p);
		int e;
		e = (act < SEL_PV_REVERSE) ? int'(p) : int'(s) - int'(p);
		// the deviation itself saturates at full scale
		e = (e > 1000) ? 1000 : (e < -1000) ? -1000 : e;
		if (act[0]) e = -e;
		e = (band == DISABLED_CODE) ? 0 : e * 1000 / int'(band);
		e = (e > 1000) ? 1000 : (e < -1000) ? -1000 : e;
		return 16'(e);
	endfunction : pexp
	// ==========
	// main sequence
	initial begin
		int i;
		void'($urandom(32'hb710));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		// defaults, read-only places and an unmapped place
		for (i = 0; i < 11; i++) begin
			rd(8'(4 * i), d);
			`CHK(d, dflt[i])
		end
		// out-of-range writes are dropped, edge values land
		for (i = 0; i < 7; i++) begin
			wr(wtab[i][47:40], wtab[i][31:16]);
			rd(wtab[i][47:40], d);
			`CHK(d, wtab[i][15:0])
		end
		// proportional answer in every action code and band
		wr(ADDR_ITIME, DISABLED_CODE);
		wr(ADDR_DTIME, DISABLED_CODE);
		sel <= 1'b1;
		for (i = 0; i < 16; i++) begin
			x = (i == 2) ? FS_NEG : 16'($urandom_range(1000)) * 16'sh0002 - 16'sh03e8;
			sp = 16'($urandom_range(500)) * 16'sh0002;
			wr(ADDR_ACTION, acts[i % 4]);
			wr(ADDR_PBAND, bands[i / 4]);
			wr(ADDR_SETPOINT, sp);
			pv <= x;
			settle();
			`CHK(sout, pexp(acts[i % 4], bands[i / 4], sp, x))
		end
		// analog set point with negative clamp, then legacy process clamp
		wr(ADDR_PBAND, 16'h03e8);
		wr(ADDR_ACTION, SEL_PV_REVERSE);
		wr(ADDR_CONFIG, 16'h0001);
		pv <= 16'sh0000;
		spin <= -16'sh012c;
		settle();
		`CHK(sout, 16'sh0000)
		@(posedge clk) spin <= 16'sh0190;
		settle();
		`CHK(sout, 16'sh0190)
		wr(ADDR_SETPOINT, 16'h0000);
		wr(ADDR_CONFIG, 16'h0002);
		pv <= -16'sh0190;
		settle();
		`CHK(sout, 16'sh0000)
		wr(ADDR_CONFIG, 16'h0000);
		settle();
		`CHK(sout, 16'sh0190)
		// limit flags at and around both limits, deviation mode, disabled limit
		wr(ADDR_UPPER, 16'h0258);
		wr(ADDR_LOWER, 16'h00c8);
		for (i = 0; i < 7; i++) begin
			if (i == 5) wr(ADDR_ACTION, SEL_DEV_FORWARD);
			if (i == 6) wr(ADDR_ACTION, SEL_PV_REVERSE);
			if (i == 6) wr(ADDR_UPPER, DISABLED_CODE);
			@(posedge clk) pv <= fpv[i];
			settle();
			`CHK({dn, up}, fexp[i])
			rd(ADDR_STATUS, d);
			`CHK(d[1:0], fexp[i])
			`CHK(d[3], 1'b1)
		end
		// integral keeps raising the output while the deviation stands
		wr(ADDR_ITIME, 16'h000a);
		wr(ADDR_SETPOINT, 16'h0064);
		pv <= 16'sh0000;
		settle();
		o1 = sout;
		repeat (40 * SC) @(posedge clk);
		@(negedge clk);
		`CHK(sout > o1, 1'b1)
		// derivative kick on a deviation step, gone one sample later
		@(posedge clk) sel <= 1'b0;
		wr(ADDR_ACTION, SEL_DEV_REVERSE);
		wr(ADDR_PBAND, DISABLED_CODE);
		wr(ADDR_ITIME, DISABLED_CODE);
		wr(ADDR_DTIME, 16'h0064);
		sel <= 1'b1;
		settle();
		`CHK(sout, 16'sh0000)
		@(posedge clk) pv <= 16'sh0032;
		for (i = 0; i < 4 * SC && sout !== FS_POS; i++) @(negedge clk);
		if (i == 4 * SC) begin
			bad_count++;
			results();
		end
		repeat (SC + 2) @(negedge clk);
		`CHK(sout, 16'sh0000)
		// closed loop with the process model free
		@(posedge clk) hold <= 1'b0;
		repeat (200) @(posedge clk);
		hold <= 1'b1;
		// pid off: the speed reference passes through
		sel <= 1'b0;
		repeat (8) @(posedge clk);
		for (i = 0; i < 20; i++) begin
			x = 16'($urandom_range(4000)) - 16'h07d0;
			@(posedge clk) sref <= x;
			@(posedge clk);
			@(negedge clk);
			`CHK(sout, x)
		end
		// direction output for every run and direction pair
		for (i = 0; i < 4; i++) begin
			wr(ADDR_CONFIG, 16'(i * 4));
			repeat (2) @(negedge clk);
			`CHK(dir, i == 3)
		end
		// reset in mid-run restores the settings
		wr(ADDR_ACTION, SEL_PV_FORWARD);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(ADDR_ACTION, d);
		`CHK(d, RST_ACTION)
		results();
	end
endmodule : pidc_top_tb
`default_nettype wire
